// ==== src/isp_pkg.sv ====
// What this block does
// - Starts sampling alone at 2048 samples per second
// - Pulses sample ready after each sample
// - Self-initializes without host configuration
// - SPI mode 3, host master, device slave
// - Sixteen-bit words, most significant bit first
// - Output line changes on falling clock edges, except the first bit of a word, which is driven when the word is loaded
// - Input line sampled on rising clock edges
// - Full duplex shifting on every transfer
// - Single read takes two transfers
// - Low request byte ignored on reads
// - Pipelined reads return previous request's data
// - Burst order: status, gyros, accels, temp, count, checksum
// - Burst words back to back, no stall
// - Link test 0x5600 returns product code
// - Sync pin direction set by misc control
package isp_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 7;
   localparam int CLK_HZ = 200000000;
   localparam int SAMPLE_RATE_SPS = 2048;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_SPS;
   localparam logic [15:0] BURST_CMD = 16'h3E00;
   // Register addresses (lower byte address)
   localparam logic [6:0] ADDR_DIAG = 7'h02;
   localparam logic [6:0] ADDR_GYRO_X = 7'h06;
   localparam logic [6:0] ADDR_GYRO_Y = 7'h0A;
   localparam logic [6:0] ADDR_GYRO_Z = 7'h0E;
   localparam logic [6:0] ADDR_ACCEL_X = 7'h12;
   localparam logic [6:0] ADDR_ACCEL_Y = 7'h16;
   localparam logic [6:0] ADDR_ACCEL_Z = 7'h1A;
   localparam logic [6:0] ADDR_COUNT = 7'h1C;
   localparam logic [6:0] ADDR_TEMP = 7'h1E;
   localparam logic [6:0] ADDR_MISC = 7'h32;
   localparam logic [6:0] ADDR_PROD = 7'h56;
   localparam logic [15:0] MISC_RESET = 16'h00C1;
   localparam int MISC_SYNC_OUT_BIT = 0;
   localparam int BURST_WORDS = 10;
endpackage : isp_pkg

// ==== src/isp_read_port.sv ====
`timescale 1ns/1ps
module isp_read_port #(
   parameter logic [15:0] PRODUCT_CODE = 16'h1234, // Arbitrary identity value
   parameter int SAMPLE_PERIOD = isp_pkg::SAMPLE_CYCLES
) (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // SPI pins
   input wire logic spi_sclk,
   input wire logic spi_cs_b,
   input wire logic spi_mosi,
   output logic spi_miso,
   // Sample sources, same clock domain
   input wire logic [isp_pkg::WORD_W-1:0] sens_gyro_x,
   input wire logic [isp_pkg::WORD_W-1:0] sens_gyro_y,
   input wire logic [isp_pkg::WORD_W-1:0] sens_gyro_z,
   input wire logic [isp_pkg::WORD_W-1:0] sens_accel_x,
   input wire logic [isp_pkg::WORD_W-1:0] sens_accel_y,
   input wire logic [isp_pkg::WORD_W-1:0] sens_accel_z,
   input wire logic [isp_pkg::WORD_W-1:0] sens_temp,
   input wire logic [isp_pkg::WORD_W-1:0] sens_diag,
   // Events and sync pin
   output logic sample_ready_pulse,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   // Received write requests
   output logic wr_valid,
   output logic [isp_pkg::ADDR_W-1:0] wr_addr,
   output logic [7:0] wr_data
);
   import isp_pkg::*;

   if (SAMPLE_PERIOD < 2)
   begin : g_bad_period
      $error("SAMPLE_PERIOD too small");
   end

   typedef enum logic [1:0] {ISP_IDLE, ISP_SINGLE, ISP_BURST} isp_mode_e;

   // Two-flop synchronisers for all pins
   logic [1:0] sclk_s, cs_s, mosi_s, sync_s;
   logic sclk_d;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sclk_s <= 2'h3;
         cs_s <= 2'h3;
         mosi_s <= 2'h0;
         sync_s <= 2'h0;
         sclk_d <= 1'b1;
      end
      else
      begin
         sclk_s <= {sclk_s[0], spi_sclk};
         cs_s <= {cs_s[0], spi_cs_b};
         mosi_s <= {mosi_s[0], spi_mosi};
         sync_s <= {sync_s[0], sync_in};
         sclk_d <= sclk_s[1];
      end
   end

   logic cs_act, rise, fall;
   assign cs_act = !cs_s[1];
   assign rise = cs_act && sclk_s[1] && !sclk_d;
   assign fall = cs_act && !sclk_s[1] && sclk_d;

   // Sample timer and output registers
   logic [31:0] tick;
   logic [15:0] snap [0:7];
   logic [15:0] sample_count;
   logic [15:0] misc_control_reg;
   logic sync_prev, sync_tick, ext_sync;
   assign ext_sync = !misc_control_reg[MISC_SYNC_OUT_BIT] && misc_control_reg[2];
   assign sync_tick = ext_sync && sync_s[1] && !sync_prev;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         tick <= 32'h0;
         sync_prev <= 1'b0;
      end
      else
      begin
         sync_prev <= sync_s[1];
         // Free-running from reset; no host set-up is needed
         if (tick == 32'(SAMPLE_PERIOD - 1) || sync_tick)
            tick <= 32'h0;
         else
            tick <= tick + 32'h1;
      end
   end

   logic sample_now;
   assign sample_now = ext_sync ? sync_tick : (tick == 32'(SAMPLE_PERIOD - 1));

   // Snapshot of sensor words; refreshed on every sample, even in the middle of a burst
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < 8; i++)
            snap[i] <= 16'h0;
         sample_count <= 16'h0;
      end
      else if (sample_now)
      begin
         snap[0] <= sens_diag;
         snap[1] <= sens_gyro_x;
         snap[2] <= sens_gyro_y;
         snap[3] <= sens_gyro_z;
         snap[4] <= sens_accel_x;
         snap[5] <= sens_accel_y;
         snap[6] <= sens_accel_z;
         snap[7] <= sens_temp;
         sample_count <= sample_count + 16'h1;
      end
   end

   // Data-ready pulse and sync output pin
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sample_ready_pulse <= 1'b0;
         sync_out <= 1'b0;
         sync_oe <= 1'b0;
      end
      else
      begin
         sample_ready_pulse <= sample_now;
         sync_oe <= misc_control_reg[MISC_SYNC_OUT_BIT];
         sync_out <= misc_control_reg[MISC_SYNC_OUT_BIT] && sample_now;
      end
   end

   // Register decode shared by single reads
   function automatic logic [15:0] reg_read(input logic [6:0] a);
      case (a)
         ADDR_DIAG: reg_read = snap[0];
         ADDR_GYRO_X: reg_read = snap[1];
         ADDR_GYRO_Y: reg_read = snap[2];
         ADDR_GYRO_Z: reg_read = snap[3];
         ADDR_ACCEL_X: reg_read = snap[4];
         ADDR_ACCEL_Y: reg_read = snap[5];
         ADDR_ACCEL_Z: reg_read = snap[6];
         ADDR_COUNT: reg_read = sample_count;
         ADDR_TEMP: reg_read = snap[7];
         ADDR_MISC: reg_read = misc_control_reg;
         ADDR_PROD: reg_read = PRODUCT_CODE;
         default: reg_read = 16'h0;
      endcase
   endfunction : reg_read

   // Checksum of the latched burst words, each byte unsigned
   function automatic logic [15:0] byte_sum(input logic [15:0] w);
      byte_sum = {8'h0, w[15:8]} + {8'h0, w[7:0]};
   endfunction : byte_sum

   // Serial shift engine
   logic [15:0] rx_sh, tx_sh, burst_sum, burst_word, rx_word;
   logic [4:0] bit_cnt;
   logic word_done;
   isp_mode_e mode;
   logic [3:0] burst_idx;
   assign rx_word = {rx_sh[14:0], mosi_s[1]};
   assign word_done = rise && bit_cnt == 5'(WORD_W - 1);

   // Burst word mux; index 8 is counter, 9 is checksum
   always_comb
   begin
      burst_word = 16'h0;
      if (burst_idx < 4'd8)
         burst_word = snap[burst_idx[2:0]];
      else if (burst_idx == 4'd8)
         burst_word = sample_count;
      else
         burst_word = burst_sum;
   end

   // Two-entry buffer between word producer and the shifter
   logic [15:0] buf_q [0:1];
   logic [1:0] buf_n;
   logic buf_wr_valid, buf_wr_ready, buf_rd_valid, buf_rd_ready, load_pend;
   logic [15:0] buf_wr_data;
   assign buf_wr_ready = buf_n != 2'd2;
   assign buf_rd_valid = buf_n != 2'd0;
   assign buf_rd_ready = cs_act && bit_cnt == 5'd0 && !fall && buf_rd_valid && load_pend;

   // Entry count and storage; a pop moves the second entry forward
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         buf_n <= 2'd0;
         buf_q[0] <= 16'h0;
         buf_q[1] <= 16'h0;
      end
      else
      begin
         case ({buf_wr_valid && buf_wr_ready, buf_rd_valid && buf_rd_ready})
            2'b10:
            begin
               buf_q[buf_n[0]] <= buf_wr_data;
               buf_n <= buf_n + 2'd1;
            end
            2'b01:
            begin
               buf_q[0] <= buf_q[1];
               buf_n <= buf_n - 2'd1;
            end
            2'b11: buf_q[0] <= buf_wr_data; // Push with pop is only possible with one entry held
            default: ;
         endcase
      end
   end

   // Producer: queue the answer for the next word at each word end
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         buf_wr_valid <= 1'b0;
         buf_wr_data <= 16'h0;
         mode <= ISP_IDLE;
         burst_idx <= 4'd0;
         burst_sum <= 16'h0;
         misc_control_reg <= MISC_RESET;
         wr_valid <= 1'b0;
         wr_addr <= 7'h0;
         wr_data <= 8'h0;
      end
      else
      begin
         wr_valid <= 1'b0;
         if (buf_wr_valid && buf_wr_ready)
            buf_wr_valid <= 1'b0;
         if (cs_s[1] && mode == ISP_BURST)
            mode <= ISP_IDLE; // Burst ends when select rises
         if (word_done && !buf_wr_valid)
         begin
            if (mode == ISP_BURST)
            begin
               // Next burst word back to back
               buf_wr_data <= burst_word;
               buf_wr_valid <= 1'b1;
               burst_sum <= burst_sum + byte_sum(burst_word);
               if (burst_idx == 4'(BURST_WORDS - 1))
                  mode <= ISP_IDLE;
               else
                  burst_idx <= burst_idx + 4'd1;
            end
            else if (rx_word == BURST_CMD)
            begin
               mode <= ISP_BURST;
               buf_wr_data <= snap[0];
               buf_wr_valid <= 1'b1;
               burst_sum <= byte_sum(snap[0]);
               burst_idx <= 4'd1;
            end
            else if (rx_word[15])
            begin
               // Write request: address and data byte
               wr_valid <= 1'b1;
               wr_addr <= rx_word[14:8];
               wr_data <= rx_word[7:0];
               if (rx_word[14:8] == ADDR_MISC)
                  misc_control_reg[7:0] <= rx_word[7:0];
               else if (rx_word[14:8] == ADDR_MISC + 7'h1)
                  misc_control_reg[15:8] <= rx_word[7:0];
               buf_wr_data <= 16'h0;
               buf_wr_valid <= 1'b1;
               mode <= ISP_SINGLE;
            end
            else
            begin
               // Low byte ignored; answer goes out next word
               buf_wr_data <= reg_read(rx_word[14:8]);
               buf_wr_valid <= 1'b1;
               mode <= ISP_SINGLE;
            end
         end
      end
   end

   // Shifter: sample on rise, drive on fall, full duplex
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rx_sh <= 16'h0;
         bit_cnt <= 5'd0;
         tx_sh <= 16'h0;
         spi_miso <= 1'b0;
         load_pend <= 1'b1;
      end
      else if (!cs_act)
      begin
         bit_cnt <= 5'd0;
         load_pend <= 1'b1;
         spi_miso <= tx_sh[15];
      end
      else
      begin
         if (buf_rd_ready)
         begin
            tx_sh <= buf_q[0];
            spi_miso <= buf_q[0][15];
            load_pend <= 1'b0;
         end
         else if (fall && bit_cnt != 5'd0)
         begin
            tx_sh <= {tx_sh[14:0], 1'b0};
            spi_miso <= tx_sh[14];
         end
         if (rise)
         begin
            rx_sh <= rx_word;
            if (word_done)
            begin
               bit_cnt <= 5'd0;
               load_pend <= 1'b1;
            end
            else
               bit_cnt <= bit_cnt + 5'd1;
         end
      end
   end
endmodule : isp_read_port

// ==== verif/isp_read_port_chk.sv ====
`timescale 1ns/1ps
module isp_read_port_chk #(
   parameter int SAMPLE_PERIOD = 200
) (
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Link pins
   input wire logic spi_sclk,
   input wire logic spi_cs_b,
   input wire logic spi_mosi,
   input wire logic spi_miso,
   // Watched outputs
   input wire logic sample_ready_pulse,
   input wire logic sync_oe,
   input wire logic wr_valid,
   input wire logic [isp_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data
);
   import isp_pkg::*;
   localparam int SLACK = 8;
   logic sclk_q, done, seen;
   logic [14:0] sh;
   logic [4:0] nbits;
   logic [15:0] word;
   int unsigned gap, fall_age, wr_age, misc_age;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Rebuild host words from raw pins; one flop only, the lag just widens windows
   always_ff @(posedge clk)
   begin
      sclk_q <= spi_sclk;
      done <= 1'b0;
      if (!rst_b || spi_cs_b)
         nbits <= 5'h00;
      else if (spi_sclk && !sclk_q)
      begin
         sh <= {sh[13:0], spi_mosi};
         nbits <= (nbits == 5'h0F) ? 5'h00 : nbits + 5'h01;
         word <= (nbits == 5'h0F) ? {sh, spi_mosi} : word;
         done <= (nbits == 5'h0F);
      end
   end
   // Cycle ages since each event
   always_ff @(posedge clk)
   begin
      gap <= (!rst_b || sample_ready_pulse) ? 0 : gap + 1;
      seen <= rst_b && (seen || sample_ready_pulse);
      fall_age <= (!spi_sclk && sclk_q) ? 0 : fall_age + 1;
      wr_age <= !rst_b ? 100 : (done && word[15]) ? 0 : wr_age + 1;
      misc_age <= !rst_b ? 100 : (wr_valid && wr_addr == ADDR_MISC) ? 0 : misc_age + 1;
   end
   pulse_width_a: assert property (sample_ready_pulse |=> !sample_ready_pulse)
      else $error("ready pulse too long");
   sample_rate_a: assert property (
      seen && sample_ready_pulse |-> gap == SAMPLE_PERIOD - 1)
      else $error("sample period wrong");
   first_sample_a: assert property (gap <= SAMPLE_PERIOD + SLACK)
      else $error("sampling stalled");
   miso_edge_a: assert property (
      $changed(spi_miso) && nbits != 5'h00 |-> fall_age <= 6)
      else $error("reply bit moved off falling clock");
   wr_word_a: assert property (
      done && word[15] |-> ##[1:8] (wr_valid && wr_addr == word[14:8] && wr_data == word[7:0]))
      else $error("write request not reported");
   wr_spur_a: assert property (wr_valid |-> wr_age <= 8)
      else $error("write reported without request");
   sync_dir_a: assert property (
      $changed(sync_oe) && $past(rst_b, 4) |-> misc_age <= 4)
      else $error("sync direction moved without control write");
   reset_quiet_a: assert property ($rose(rst_b) |-> !sample_ready_pulse && !wr_valid)
      else $error("events during reset");
endmodule : isp_read_port_chk

bind isp_read_port isp_read_port_chk #(
   .SAMPLE_PERIOD(SAMPLE_PERIOD)
) chk (
   .clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
   .spi_mosi(spi_mosi), .spi_miso(spi_miso), .sample_ready_pulse(sample_ready_pulse),
   .sync_oe(sync_oe), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data)
);

// ==== verif/isp_host_model.sv ====
`timescale 1ns/1ps
module isp_host_model #(
   parameter int STALL_NS = 16000
) (
   // Host driven pins
   output logic spi_sclk,
   output logic spi_cs_b,
   output logic spi_mosi,
   // Device reply
   input wire logic spi_miso
);
   // Idle: clock parked high, select released
   initial
   begin
      spi_sclk = 1'b1;
      spi_cs_b = 1'b1;
      spi_mosi = 1'b1;
   end
   // One word; keep holds select low so the next burst word follows at once
   task automatic xfer(input logic [15:0] tx, input bit keep, output logic [15:0] rx);
      if (spi_cs_b)
      begin
         spi_cs_b = 1'b0;
         #200;
      end
      for (int i = 15; i >= 0; i--)
      begin
         spi_sclk = 1'b0;
         spi_mosi = tx[i];
         #24;
         spi_sclk = 1'b1;
         rx[i] = spi_miso;
         #24;
      end
      if (!keep)
      begin
         spi_mosi = ~tx[0]; // Stale data would hide a late sampler
         spi_cs_b = 1'b1;
         #(STALL_NS);
      end
   endtask : xfer
endmodule : isp_host_model

// ==== verif/imu_spi_read_port_test.sv ====
`timescale 1ns/1ps
module imu_spi_read_port_test;
   import isp_pkg::*;
   localparam int PERIOD = 200;
   localparam logic [15:0] PCODE = 16'h2B7D; // Arbitrary identity value
   logic clk, rst_b, spi_sclk, spi_cs_b, spi_mosi, spi_miso, sample_ready_pulse;
   logic sync_out, sync_oe, wr_valid;
   logic [ADDR_W-1:0] wr_addr, got_addr;
   logic [7:0] wr_data, got_data;
   // Sensor words in burst order: status, gyro x y z, accel x y z, temperature
   logic [15:0] sv [8] = '{16'h5A01, 16'h8123, 16'h7F3E, 16'hFFC0, 16'h0102, 16'hE4D5,
      16'h3C00, 16'h19AB};
   int n_errors = 0;
   int checks = 0;

   isp_read_port #(.PRODUCT_CODE(PCODE), .SAMPLE_PERIOD(PERIOD)) dut (
      .clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .sens_gyro_x(sv[1]), .sens_gyro_y(sv[2]),
      .sens_gyro_z(sv[3]), .sens_accel_x(sv[4]), .sens_accel_y(sv[5]),
      .sens_accel_z(sv[6]), .sens_temp(sv[7]), .sens_diag(sv[0]),
      .sample_ready_pulse(sample_ready_pulse), .sync_in(1'b0), .sync_out(sync_out),
      .sync_oe(sync_oe), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
   isp_host_model host (.spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso));

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Keep the last reported write request
   always @(posedge clk)
      if (wr_valid)
         {got_addr, got_data} <= {wr_addr, wr_data};

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t word %h, expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic end_of_test();
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   // Bounded wait for the next ready pulse; n is the number of edges waited
   task automatic wait_pulse(output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end while (sample_ready_pulse !== 1'b1 && n < 3 * PERIOD);
      if (sample_ready_pulse !== 1'b1)
      begin
         n_errors++;
         $display("[ERR] %0t no ready pulse", $time);
         end_of_test();
      end
   endtask : wait_pulse

   task automatic t_rate();
      int n;
      wait_pulse(n);
      chk_bit(n <= PERIOD + 8, 1'b1);
      // Direction follows the control register one edge after reset, so look only now
      chk_bit(sync_oe, MISC_RESET[MISC_SYNC_OUT_BIT]);
      chk_bit(sync_out, 1'b1);
      wait_pulse(n);
      chk_word(16'(n), 16'(PERIOD));
      @(posedge clk);
      #1;
      chk_bit(sample_ready_pulse, 1'b0);
      chk_bit(sync_out, 1'b0);
   endtask : t_rate

   // Pipelined reads, junk low bytes, repeated id request, unmapped address
   task automatic t_single();
      logic [15:0] rx;
      logic [15:0] req [8];
      logic [15:0] exp [8];
      req = '{16'h0600, 16'h0A00, 16'h0E00, 16'h02C7, 16'h56FF, 16'h5600, 16'h4C00, 16'h0000};
      exp = '{16'h0000, sv[1], sv[2], sv[3], sv[0], PCODE, PCODE, 16'h0000};
      for (int i = 0; i < 8; i++)
      begin
         host.xfer(req[i], 1'b0, rx);
         if (i > 0)
            chk_word(rx, exp[i]);
      end
   endtask : t_single

   task automatic t_burst();
      logic [15:0] rx;
      logic [15:0] sum;
      sum = 16'h0000;
      host.xfer(BURST_CMD, 1'b1, rx);
      for (int i = 0; i < 9; i++)
      begin
         host.xfer(16'h0000, 1'b1, rx);
         sum = sum + rx[15:8] + rx[7:0];
         if (i < 8)
            chk_word(rx, sv[i]);
      end
      host.xfer(16'h0000, 1'b0, rx);
      chk_word(rx, sum);
   endtask : t_burst

   task automatic t_write();
      logic [15:0] rx;
      host.xfer(16'hB200, 1'b0, rx);
      chk_word({1'b1, got_addr, got_data}, 16'hB200);
      chk_bit(sync_oe, 1'b0);
      host.xfer(16'hB201, 1'b0, rx);
      chk_bit(sync_oe, 1'b1);
      host.xfer({1'b0, ADDR_MISC, 8'h00}, 1'b0, rx);
      host.xfer(16'h0000, 1'b0, rx);
      chk_word(rx, {MISC_RESET[15:8], 8'h01});
   endtask : t_write

   // Reset for three cycles, then run every scenario
   initial
   begin
      rst_b = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_b = 1'b1;
      t_rate();
      t_single();
      t_burst();
      t_write();
      end_of_test();
   end
endmodule : imu_spi_read_port_test
